// *** cpu_store_transfer_decode.v ***
// store, transfer, memory test and halt execution with an apb register port
// Operation
// - accumulator store: zp 85/4/2, zp-x 95/5/2, abs 8d/5/3
// - accumulator store: abs-x 9d, abs-y 99 6/3; indirect_x_mode 81, indirect_y_mode 91 7/2; no flags
// - x store: zp 86/4/2, zp-y 96/5/2, abs 8e/5/3; no flag change
// - y store: zp 84/4/2, zp-x 94/5/2, abs 8c/5/3; no flag change
// - aa copies accumulator to x, 2 cycles, 1 byte, updates n and z
// - a8 copies accumulator to y, 2 cycles, 1 byte, updates n and z
// - 64 zero page test, 3 cycles, sets n and z, memory untouched
// - ba copies stack pointer to x, 2 cycles, 1 byte, updates n and z
// - 8a copies x to accumulator, 2 cycles, 1 byte, updates n and z
// - 9a copies x to stack pointer, 2 cycles, 1 byte, no flag change
// - 98 copies y to accumulator, 2 cycles, 1 byte, updates n and z
// - c2 halts internal clock, 42 halts oscillator; 2 cycles, no flags
// - with t flag set, marked instructions take 3, 2 or 1 extra cycles
// - taken relative branches take two extra cycles
// - in decimal mode arithmetic leaves n, v and z undefined
`timescale 1ns/10ps
`include "cpu_xfer_defines.vh"
module cpu_store_transfer_decode #(
  parameter MEM_AW = 10
) (
  input wire core_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  output reg busy_q,
  output reg osc_halt_q,
  output reg clk_halt_q
);

  localparam S_IDLE = 3'h0;
  localparam S_PTRL = 3'h1;
  localparam S_PTRH = 3'h2;
  localparam S_PTRD = 3'h3;
  localparam S_ACT = 3'h4;
  localparam S_TST = 3'h5;
  localparam S_WAIT = 3'h6;

  reg [7:0] acc_q;
  reg [7:0] x_q;
  reg [7:0] y_q;
  reg [7:0] sp_q;
  reg [7:0] ps_q;
  reg [2:0] state_q;
  reg [3:0] cnt_q;
  reg [23:0] cmd_q;
  reg [2:0] kind_q;
  reg [3:0] mode_q;
  reg [1:0] src_q;
  reg [1:0] dst_q;
  reg nz_q;
  reg [15:0] ea_q;
  reg [7:0] ptr_q;
  reg bad_q;
  reg [3:0] cyc_q;

  wire dec_valid;
  wire [2:0] dec_kind;
  wire [3:0] dec_mode;
  wire [1:0] dec_src;
  wire [1:0] dec_dst;
  wire dec_nz;
  wire [3:0] dec_cycles;
  wire [1:0] dec_bytes;
  wire [1:0] dec_ext;
  wire [7:0] mem_rdata;

  op_decode u_dec (
    .opcode(pwdata[7:0]),
    .valid(dec_valid),
    .kind(dec_kind),
    .mode(dec_mode),
    .src(dec_src),
    .dst(dec_dst),
    .nz_upd(dec_nz),
    .cycles(dec_cycles),
    .bytes(dec_bytes),
    .ext(dec_ext)
  );

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire setup = psel & ~penable;
  wire acc_ph = psel & penable;
  wire wr = acc_ph & pwrite;
  wire mapped = (paddr <= `REG_STAT) && (paddr[1:0] == 2'h0);
  wire halted = osc_halt_q | clk_halt_q;
  // a command is only taken while idle and running; others are dropped silently
  wire cmd_go = wr && (paddr == `REG_CMD) && !busy_q && !halted;
  wire reg_wr = wr && !busy_q;

  // ----------------------------------------
  // cycle count with t extension
  // ----------------------------------------
  // the extension table is wired in although none of these opcodes is marked;
  // relative branches are outside this decoder, so no taken-branch term is added
  reg [3:0] ext_add;
  always @* begin
    case (dec_ext)
      `EXT_THREE: ext_add = 4'h3;
      `EXT_TWO: ext_add = 4'h2;
      `EXT_ONE: ext_add = 4'h1;
      default: ext_add = 4'h0;
    endcase
  end
  wire [3:0] total_cyc = dec_cycles + (ps_q[`PS_T] ? ext_add : 4'h0);

  // ----------------------------------------
  // operand address forming
  // ----------------------------------------
  wire [7:0] op_lo = cmd_q[15:8];
  wire [7:0] op_hi = cmd_q[23:16];
  wire [7:0] new_lo = pwdata[15:8];
  reg [15:0] ea_dir;
  always @* begin
    case (dec_mode)
      `MODE_ZPX: ea_dir = {8'h00, new_lo + x_q};
      `MODE_ZPY: ea_dir = {8'h00, new_lo + y_q};
      `MODE_ABS: ea_dir = pwdata[23:8];
      `MODE_ABSX: ea_dir = pwdata[23:8] + {8'h00, x_q};
      `MODE_ABSY: ea_dir = pwdata[23:8] + {8'h00, y_q};
      default: ea_dir = {8'h00, new_lo};
    endcase
  end

  // ----------------------------------------
  // data source select
  // ----------------------------------------
  reg [7:0] src_val;
  always @* begin
    case (src_q)
      `SRC_X: src_val = x_q;
      `SRC_Y: src_val = y_q;
      `SRC_SP: src_val = sp_q;
      default: src_val = acc_q;
    endcase
  end

  // ----------------------------------------
  // memory port
  // ----------------------------------------
  // store writes in the act step; test reads ea and checks it one cycle later
  wire mem_we = (state_q == S_ACT) && (kind_q == `KIND_STORE);
  reg [15:0] mem_ra;
  always @* begin
    case (state_q)
      S_PTRL: mem_ra = {8'h00, ptr_q};
      S_PTRH: mem_ra = {8'h00, ptr_q + 8'h01}; // pointer high byte wraps in page zero
      default: mem_ra = ea_q;
    endcase
  end

  data_mem #(
    .AW(MEM_AW),
    .DW(8)
  ) u_mem (
    .core_clk(core_clk),
    .we(mem_we),
    .waddr(ea_q[MEM_AW-1:0]),
    .wdata(src_val),
    .raddr(mem_ra[MEM_AW-1:0]),
    .rdata(mem_rdata)
  );

  // ----------------------------------------
  // execution sequencer
  // ----------------------------------------
  // busy holds for exactly the instruction's cycle count after the command
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      cmd_q <= 24'h000000;
      kind_q <= `KIND_STORE;
      mode_q <= `MODE_IMP;
      src_q <= `SRC_ACC;
      dst_q <= `SRC_ACC;
      nz_q <= 1'b0;
      ea_q <= 16'h0000;
      ptr_q <= 8'h00;
      cyc_q <= 4'h0;
    end else begin
      if (cmd_go && dec_valid) begin
        cmd_q <= pwdata[23:0];
        kind_q <= dec_kind;
        mode_q <= dec_mode;
        src_q <= dec_src;
        dst_q <= dec_dst;
        nz_q <= dec_nz;
        ea_q <= ea_dir;
        cnt_q <= total_cyc;
        cyc_q <= total_cyc;
        busy_q <= 1'b1;
        if (dec_mode == `MODE_INDX) begin
          ptr_q <= new_lo + x_q;
          state_q <= S_PTRL;
        end else if (dec_mode == `MODE_INDY) begin
          ptr_q <= new_lo;
          state_q <= S_PTRL;
        end else begin
          state_q <= S_ACT;
        end
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
        case (state_q)
          S_PTRL: state_q <= S_PTRH;
          S_PTRH: begin
            ea_q[7:0] <= mem_rdata;
            state_q <= S_PTRD;
          end
          S_PTRD: begin
            ea_q <= {mem_rdata, ea_q[7:0]} + ((mode_q == `MODE_INDY) ? {8'h00, y_q} : 16'h0000);
            state_q <= S_ACT;
          end
          S_ACT: state_q <= (kind_q == `KIND_TEST) ? S_TST : S_WAIT;
          S_TST: state_q <= S_WAIT;
          S_WAIT: begin
            if (cnt_q == 4'h1) begin
              busy_q <= 1'b0;
              state_q <= S_IDLE;
            end
          end
          default: begin
            busy_q <= 1'b0;
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // architectural registers and flags
  // ----------------------------------------
  // stores and halts leave ps alone; software may write registers only when idle
  wire do_act = busy_q && (state_q == S_ACT);
  wire nz_set = do_act && (kind_q == `KIND_XFER) && nz_q;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      acc_q <= `REG_RST;
      x_q <= `REG_RST;
      y_q <= `REG_RST;
      sp_q <= `SP_RST;
      ps_q <= `PS_RST;
    end else begin
      if (do_act && (kind_q == `KIND_XFER)) begin
        case (dst_q)
          `SRC_X: x_q <= src_val;
          `SRC_Y: y_q <= src_val;
          `SRC_SP: sp_q <= src_val;
          default: acc_q <= src_val;
        endcase
      end else if (reg_wr && paddr == `REG_ACC) begin
        acc_q <= pwdata[7:0];
      end else if (reg_wr && paddr == `REG_IDX_X) begin
        x_q <= pwdata[7:0];
      end else if (reg_wr && paddr == `REG_IDX_Y) begin
        y_q <= pwdata[7:0];
      end else if (reg_wr && paddr == `REG_SP) begin
        sp_q <= pwdata[7:0];
      end
      // n and z follow the moved value; d has no say since these are not arithmetic
      if (nz_set) begin
        ps_q[`PS_N] <= src_val[7];
        ps_q[`PS_Z] <= (src_val == 8'h00);
      end else if (busy_q && state_q == S_TST) begin
        ps_q[`PS_N] <= mem_rdata[7];
        ps_q[`PS_Z] <= (mem_rdata == 8'h00);
      end else if (reg_wr && paddr == `REG_PS) begin
        ps_q <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // halt and error flags
  // ----------------------------------------
  // writing one clears a flag; a set in the same cycle wins over the clear
  wire clr = wr && (paddr == `REG_STAT);
  always @(posedge core_clk) begin
    if (!rst_n) begin
      osc_halt_q <= 1'b0;
      clk_halt_q <= 1'b0;
      bad_q <= 1'b0;
    end else begin
      if (do_act && kind_q == `KIND_OSC_HALT) begin
        osc_halt_q <= 1'b1;
      end else if (clr && pwdata[`ST_OSC]) begin
        osc_halt_q <= 1'b0;
      end
      if (do_act && kind_q == `KIND_CLK_HALT) begin
        clk_halt_q <= 1'b1;
      end else if (clr && pwdata[`ST_CLK]) begin
        clk_halt_q <= 1'b0;
      end
      if (cmd_go && !dec_valid) begin
        bad_q <= 1'b1;
      end else if (clr && pwdata[`ST_BAD]) begin
        bad_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // apb read mux and answer
  // ----------------------------------------
  reg [31:0] rd_mux;
  always @* begin
    case (paddr)
      `REG_CMD: rd_mux = {8'h00, cmd_q};
      `REG_ACC: rd_mux = {24'h000000, acc_q};
      `REG_IDX_X: rd_mux = {24'h000000, x_q};
      `REG_IDX_Y: rd_mux = {24'h000000, y_q};
      `REG_SP: rd_mux = {24'h000000, sp_q};
      `REG_PS: rd_mux = {24'h000000, ps_q};
      `REG_STAT: rd_mux = {20'h00000, cyc_q, 4'h0, bad_q, clk_halt_q, osc_halt_q, busy_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // data is sampled in the setup cycle so the access phase ends in its first cycle, with no wait state
  always @(posedge core_clk) begin
    if (!rst_n) begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end
endmodule

// *** cpu_xfer_defines.vh ***
// constants shared by the store/transfer decode block
`ifndef CPU_XFER_DEFINES_VH
`define CPU_XFER_DEFINES_VH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_STA_ZP 8'h85
`define OP_STA_ZPX 8'h95
`define OP_STA_ABS 8'h8d
`define OP_STA_ABSX 8'h9d
`define OP_STA_ABSY 8'h99
`define OP_STA_INDX 8'h81
`define OP_STA_INDY 8'h91
`define OP_STX_ZP 8'h86
`define OP_STX_ZPY 8'h96
`define OP_STX_ABS 8'h8e
`define OP_STY_ZP 8'h84
`define OP_STY_ZPX 8'h94
`define OP_STY_ABS 8'h8c
`define OP_TAX 8'haa
`define OP_TAY 8'ha8
`define OP_TST_ZP 8'h64
`define OP_TSX 8'hba
`define OP_TXA 8'h8a
`define OP_TXS 8'h9a
`define OP_TYA 8'h98
`define OP_CLK_HALT 8'hc2
`define OP_OSC_HALT 8'h42

// ----------------------------------------
// addressing modes, kinds, data sources
// ----------------------------------------
`define MODE_IMP 4'h0
`define MODE_ZP 4'h1
`define MODE_ZPX 4'h2
`define MODE_ZPY 4'h3
`define MODE_ABS 4'h4
`define MODE_ABSX 4'h5
`define MODE_ABSY 4'h6
`define MODE_INDX 4'h7
`define MODE_INDY 4'h8
`define KIND_STORE 3'h0
`define KIND_XFER 3'h1
`define KIND_TEST 3'h2
`define KIND_CLK_HALT 3'h3
`define KIND_OSC_HALT 3'h4
`define SRC_ACC 2'h0
`define SRC_X 2'h1
`define SRC_Y 2'h2
`define SRC_SP 2'h3
`define EXT_NONE 2'h0
`define EXT_ONE 2'h3
`define EXT_TWO 2'h2
`define EXT_THREE 2'h1

// ----------------------------------------
// status word bits and reset values
// ----------------------------------------
`define PS_C 0
`define PS_Z 1
`define PS_I 2
`define PS_D 3
`define PS_B 4
`define PS_T 5
`define PS_V 6
`define PS_N 7
`define PS_RST 8'h00
`define SP_RST 8'hff
`define REG_RST 8'h00

// ----------------------------------------
// register offsets and status bits
// ----------------------------------------
`define REG_CMD 8'h00
`define REG_ACC 8'h04
`define REG_IDX_X 8'h08
`define REG_IDX_Y 8'h0c
`define REG_SP 8'h10
`define REG_PS 8'h14
`define REG_STAT 8'h18
`define ST_BUSY 0
`define ST_OSC 1
`define ST_CLK 2
`define ST_BAD 3
`endif

// *** op_decode.v ***
// opcode table: kind, mode, cycles, length and flag effect per opcode
`timescale 1ns/10ps
`include "cpu_xfer_defines.vh"
module op_decode (
  input wire [7:0] opcode,
  output reg valid,
  output reg [2:0] kind,
  output reg [3:0] mode,
  output reg [1:0] src,
  output reg [1:0] dst,
  output reg nz_upd,
  output reg [3:0] cycles,
  output reg [1:0] bytes,
  output reg [1:0] ext
);

  // ----------------------------------------
  // decode table
  // ----------------------------------------
  // none of these opcodes carries an extension mark, so ext stays none
  always @* begin
    valid = 1'b1;
    kind = `KIND_STORE;
    mode = `MODE_IMP;
    src = `SRC_ACC;
    dst = `SRC_ACC;
    nz_upd = 1'b0;
    cycles = 4'h2;
    bytes = 2'h1;
    ext = `EXT_NONE;
    case (opcode)
      `OP_STA_ZP: begin mode = `MODE_ZP; cycles = 4'h4; bytes = 2'h2; end
      `OP_STA_ZPX: begin mode = `MODE_ZPX; cycles = 4'h5; bytes = 2'h2; end
      `OP_STA_ABS: begin mode = `MODE_ABS; cycles = 4'h5; bytes = 2'h3; end
      `OP_STA_ABSX: begin mode = `MODE_ABSX; cycles = 4'h6; bytes = 2'h3; end
      `OP_STA_ABSY: begin mode = `MODE_ABSY; cycles = 4'h6; bytes = 2'h3; end
      `OP_STA_INDX: begin mode = `MODE_INDX; cycles = 4'h7; bytes = 2'h2; end
      `OP_STA_INDY: begin mode = `MODE_INDY; cycles = 4'h7; bytes = 2'h2; end
      `OP_STX_ZP: begin src = `SRC_X; mode = `MODE_ZP; cycles = 4'h4; bytes = 2'h2; end
      `OP_STX_ZPY: begin src = `SRC_X; mode = `MODE_ZPY; cycles = 4'h5; bytes = 2'h2; end
      `OP_STX_ABS: begin src = `SRC_X; mode = `MODE_ABS; cycles = 4'h5; bytes = 2'h3; end
      `OP_STY_ZP: begin src = `SRC_Y; mode = `MODE_ZP; cycles = 4'h4; bytes = 2'h2; end
      `OP_STY_ZPX: begin src = `SRC_Y; mode = `MODE_ZPX; cycles = 4'h5; bytes = 2'h2; end
      `OP_STY_ABS: begin src = `SRC_Y; mode = `MODE_ABS; cycles = 4'h5; bytes = 2'h3; end
      `OP_TAX: begin kind = `KIND_XFER; dst = `SRC_X; nz_upd = 1'b1; end
      `OP_TAY: begin kind = `KIND_XFER; dst = `SRC_Y; nz_upd = 1'b1; end
      `OP_TST_ZP: begin kind = `KIND_TEST; mode = `MODE_ZP; cycles = 4'h3; bytes = 2'h2; end
      `OP_TSX: begin kind = `KIND_XFER; src = `SRC_SP; dst = `SRC_X; nz_upd = 1'b1; end
      `OP_TXA: begin kind = `KIND_XFER; src = `SRC_X; nz_upd = 1'b1; end
      `OP_TXS: begin kind = `KIND_XFER; src = `SRC_X; dst = `SRC_SP; end
      `OP_TYA: begin kind = `KIND_XFER; src = `SRC_Y; nz_upd = 1'b1; end
      `OP_CLK_HALT: kind = `KIND_CLK_HALT;
      `OP_OSC_HALT: kind = `KIND_OSC_HALT;
      default: valid = 1'b0;
    endcase
  end
endmodule

// *** data_mem.v ***
// small data memory: one write port, one read port with registered data
`timescale 1ns/10ps
module data_mem #(
  parameter AW = 10,
  parameter DW = 8
) (
  input wire core_clk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // read before write: a same-cycle read of the written cell sees old data
  always @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// *** mem_ref_model.sv ***
// reference copy of the data memory that sits behind the store path
`timescale 1ns/10ps
module mem_ref_model #(
  parameter AW = 10
);
  // ----------------------------------------
  // storage, written and read by the bench model only
  // ----------------------------------------
  // kept as bytes so pointer fetches for indirect modes read like the core does
  logic [7:0] mem [0:(1<<AW)-1];
endmodule

// *** xfer_monitor.sv ***
// assertion checker for the store/transfer decode block
`timescale 1ns/10ps
module xfer_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_q,
  input wire logic pready_q,
  input wire logic pslverr_q,
  input wire logic busy_q,
  input wire logic osc_halt_q,
  input wire logic clk_halt_q
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // a command only starts when the core is idle and not halted
  wire logic take = psel && penable && pready_q && pwrite;
  wire logic go = take && paddr == 8'h00 && !busy_q && !osc_halt_q && !clk_halt_q;
  wire logic [7:0] op = pwdata[7:0];
  wire logic bad = paddr > 8'h18 || paddr[1:0] != 2'b00;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  AST_RDY_PULSE: assert property (pready_q |=> !pready_q)
    else $error("ready held longer than one cycle");
  AST_RDY_SETUP: assert property (psel && !penable |=> pready_q)
    else $error("no ready after setup cycle");
  AST_ERR_MAP: assert property (psel && !penable && bad |=> pslverr_q && pready_q)
    else $error("unmapped access not refused");
  AST_ERR_OK: assert property (psel && !penable && !bad |=> !pslverr_q)
    else $error("mapped access refused");
  AST_AA_TWO: assert property (go && op == 8'haa |=> busy_q [*2] ##1 !busy_q)
    else $error("accumulator to x cycle count wrong");
  AST_ZP_FOUR: assert property (go && op == 8'h85 |=> busy_q [*4] ##1 !busy_q)
    else $error("zero page store cycle count wrong");
  AST_TEST_THREE: assert property (go && op == 8'h64 |=> busy_q [*3] ##1 !busy_q)
    else $error("memory test cycle count wrong");
  AST_ABSX_SIX: assert property (go && op == 8'h9d |=> busy_q [*6] ##1 !busy_q)
    else $error("absolute x store cycle count wrong");
  AST_INDY_SEVEN: assert property (go && op == 8'h91 |=> busy_q [*7] ##1 !busy_q)
    else $error("indirect y store cycle count wrong");
  AST_STX_FIVE: assert property (go && op == 8'h8e |=> busy_q [*5] ##1 !busy_q)
    else $error("absolute x-register store cycle count wrong");
  AST_STY_FIVE: assert property (go && op == 8'h94 |=> busy_q [*5] ##1 !busy_q)
    else $error("zero page x y-register store cycle count wrong");
  AST_CLK_HALT_SET: assert property (go && op == 8'hc2 |-> ##[1:4] clk_halt_q)
    else $error("clock halt flag not set");
  AST_OSC_STICKY: assert property (osc_halt_q && !(take && paddr == 8'h18) |=> osc_halt_q)
    else $error("oscillator halt flag dropped");
  AST_HALT_BLOCKS: assert property (take && paddr == 8'h00 && clk_halt_q && !busy_q |=> !busy_q)
    else $error("command started while halted");
  cover property (go && op == 8'h91);
  cover property (pslverr_q);
  cover property ($rose(clk_halt_q));
endmodule
bind cpu_store_transfer_decode xfer_monitor xfer_monitor_i (.core_clk(core_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .busy_q(busy_q),
  .osc_halt_q(osc_halt_q), .clk_halt_q(clk_halt_q));

// *** cpu_store_transfer_decode_tb_top.sv ***
// self-checking bench for the store/transfer decode block
`timescale 1ns/10ps
module cpu_store_transfer_decode_tb_top;
  logic core_clk = 0;
  logic rst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata_q, rv;
  logic pready_q, pslverr_q, busy_q, osc_halt_q, clk_halt_q, re;
  int n_errors = 0;
  int comparisons = 0;
  int m[5];
  int n, op, lo, e, v, p;
  int xo[6] = '{'haa, 'ha8, 'hba, 'h8a, 'h9a, 'h98};
  int so[13] = '{'h85, 'h95, 'h8d, 'h9d, 'h99, 'h81, 'h91, 'h86, 'h96, 'h8e, 'h84, 'h94, 'h8c};
  always #4 core_clk = ~core_clk;
  cpu_store_transfer_decode #(.MEM_AW(10)) cpu_store_transfer_decode_i (.core_clk(core_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .busy_q(busy_q), .osc_halt_q(osc_halt_q), .clk_halt_q(clk_halt_q));
  mem_ref_model #(.AW(10)) mem_ref_model_i ();
  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task stop_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // ----------------------------------------
  // apb master and command helpers
  // ----------------------------------------
  // one idle edge first so a request never reuses the release edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready_q !== 1'b1 && k < 20);
    rv = prdata_q;
    re = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready_q !== 1'b1) begin
      n_errors++;
      stop_test();
    end
  endtask
  // counts busy cycles; bounded so a stuck core ends the run
  task run(input int o, input int l);
    apb(1'b1, 8'h00, 32'(o) | (32'(l) << 8));
    n = 0;
    @(posedge core_clk);
    while (busy_q === 1'b1 && n < 60) begin
      n++;
      @(posedge core_clk);
    end
    if (n >= 60) begin
      n_errors++;
      stop_test();
    end
  endtask
  task check_regs;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 + 4 * i), 32'h0);
      check($sformatf("reg %0d", i), rv, 32'(m[i]));
    end
  endtask
  // r picks all-zero, all-0x80 or random contents; mk limits the index registers
  task setv(input int r, input int mk);
    for (int i = 0; i < 5; i++) begin
      v = (r == 0) ? 0 : (r == 1) ? 'h80 : ($urandom & 'hff);
      m[i] = (i == 1 || i == 2) ? (v & mk) : v;
      apb(1'b1, 8'(4 + 4 * i), 32'(m[i]));
    end
  endtask
  task store_zp(input int a, input int d);
    m[0] = d;
    apb(1'b1, 8'h04, 32'(d));
    run('h85, a);
    mem_ref_model_i.mem[a] = 8'(d);
  endtask
  function int nz(input int ps, input int d);
    return (ps & 'h7d) | (d & 'h80) | ((d == 0) ? 2 : 0);
  endfunction
  function int ea(input int o, input int l);
    case (o)
      'h95, 'h94: return (l + m[1]) & 'hff;
      'h96: return (l + m[2]) & 'hff;
      'h9d: return l + m[1];
      'h99: return l + m[2];
      'h81: return mem_ref_model_i.mem[(l + m[1]) & 'hff];
      'h91: return mem_ref_model_i.mem[l] + m[2];
      default: return l;
    endcase
  endfunction
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(75));
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    m = '{0, 0, 0, 'hff, 0};
    check_regs();
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped err", re, 1);
    check("unmapped data", rv, 0);
    apb(1'b1, 8'h02, 32'h0);
    check("misaligned err", re, 1);
    // register transfers; random status also sets t and d, which must not matter
    for (int r = 0; r < 4; r++) begin
      foreach (xo[i]) begin
        setv(r, 'hff);
        run(xo[i], 0);
        check("xfer cycles", n, 2);
        case (xo[i])
          'haa: m[1] = m[0];
          'ha8: m[2] = m[0];
          'hba: m[1] = m[3];
          'h8a: m[0] = m[1];
          'h9a: m[3] = m[1];
          default: m[0] = m[2];
        endcase
        v = (xo[i] == 'h9a) ? m[3] : m[(xo[i] == 'ha8) ? 2 : (xo[i] == 'haa || xo[i] == 'hba)];
        if (xo[i] != 'h9a)
          m[4] = nz(m[4], v);
        check_regs();
      end
    end
    // stores, each read back through the zero page memory test
    for (int r = 0; r < 3; r++) begin
      foreach (so[i]) begin
        op = so[i];
        lo = $urandom & 'h7f;
        setv(r, 'h1f);
        if (op == 'h81 || op == 'h91) begin
          p = (op == 'h81) ? ((lo + m[1]) & 'hff) : lo;
          store_zp(p, $urandom % 100);
          store_zp((p + 1) & 'hff, 0);
          m[0] = (r == 0) ? 0 : ($urandom & 'hff);
          apb(1'b1, 8'h04, 32'(m[0]));
        end
        e = ea(op, lo);
        v = (op == 'h86 || op == 'h96 || op == 'h8e) ? m[1] :
            (op == 'h84 || op == 'h94 || op == 'h8c) ? m[2] : m[0];
        run(op, lo);
        check("store cycles", n, (op & 'h0f) == 1 ? 7 : (op == 'h9d || op == 'h99) ? 6 :
              (op & 'hf0) == 'h90 || (op & 'h0f) > 'hb ? 5 : 4);
        mem_ref_model_i.mem[e] = 8'(v);
        check_regs();
        run('h64, e);
        check("test cycles", n, 3);
        m[4] = nz(m[4], v);
        check_regs();
      end
    end
    // halts block commands until cleared by writing one to the status bit
    foreach (xo[i]) if (i < 2) begin
      op = (i == 0) ? 'hc2 : 'h42;
      run(op, 0);
      check("halt cycles", n, 2);
      apb(1'b0, 8'h18, 32'h0);
      check("halt flag", rv[2 - i], 1);
      run('haa, 0);
      check("halted start", n, 0);
      check_regs();
      apb(1'b1, 8'h18, 32'(4 >> i));
      apb(1'b0, 8'h18, 32'h0);
      check("halt cleared", rv[2 - i], 0);
    end
    // register write during execution is dropped
    run('h85, 5);
    apb(1'b1, 8'h00, 32'h0585);
    apb(1'b1, 8'h04, 32'h5a);
    run('h64, 5);
    m[4] = nz(m[4], m[0]);
    check_regs();
    run('hea, 0);
    apb(1'b0, 8'h18, 32'h0);
    check("bad opcode", rv[3], 1);
    stop_test();
  end
endmodule
